// File: scr_control_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"
module scr_control_regs (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Register access from the serial control bus engine.
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Straps and configuration inputs.
    input wire [6:0] address_strap_pin,
    input wire second_port_bus_enable,
    input wire second_port_select,
    // Link and pixel status pins.
    input wire link_detected,
    input wire pclk_present,
    input wire remote_nack,
    // Video timing inputs sampled on the pixel clock rate.
    input wire horizontal_sync,
    input wire vertical_sync,
    input wire pixel_valid_strobe,
    // Controls toward the datapath.
    output reg [6:0] port0_address,
    output reg [6:0] port1_address,
    output reg power_down,
    output reg logic_reset,
    output reg crc_check_en,
    output reg [1:0] auto_ack_en,
    output reg [1:0] pass_through_en,
    output reg use_internal_osc,
    output reg nack_to_master,
    output reg horizontal_sync_out,
    output reg vertical_sync_out,
    output reg pixel_valid_out
);
    reg [6:0] strap_s1_r, strap_s2_r;
    reg [1:0] ctl_s1_r, ctl_s2_r;
    reg [5:0] pin_s1_r, pin_s2_r;
    reg strap_taken_r;
    reg [6:0] addr0_r, addr1_r;
    reg [1:0] src_r;
    reg sleep_r;
    reg crc_r, filt_r, pclk_auto_r;
    reg [1:0] ack_r, pass_r;
    reg [3:0] rst_cnt_r;
    reg full_rst_r;
    wire [2:0] filt_out;
    localparam [7:0] gen_rst_val = `SCR_GEN_RESET;
    localparam [7:0] rst_rst_val = `SCR_RST_RESET;

    function scr_port_bit;
        input [1:0] vec;
        input sel;
        begin
            scr_port_bit = sel ? vec[1] : vec[0];
        end
    endfunction

    function scr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            scr_hit = addr == ofs;
        end
    endfunction

    wire sel1 = ctl_s2_r[1];
    wire p1en = ctl_s2_r[0];
    wire [6:0] strap = strap_s2_r;
    wire regs_rst = reset | full_rst_r;
    wire wr_addr = reg_wr && scr_hit(reg_addr, `SCR_OFS_ADDR);
    wire wr_rst = reg_wr && scr_hit(reg_addr, `SCR_OFS_RST);
    wire wr_gen = reg_wr && scr_hit(reg_addr, `SCR_OFS_GEN);
    wire [2:0] vid_in = pin_s2_r[5:3];
    wire [7:0] gen_rd_val = {crc_r, gen_rst_val[`SCR_BIT_GEN_FIXED], scr_port_bit(ack_r, sel1), filt_r,
        scr_port_bit(pass_r, sel1), 1'b0, pclk_auto_r, 1'b0};

    // Two-flop synchronisers for every pin from outside the clock domain.
    always @(posedge clk) begin
        strap_s1_r <= address_strap_pin;
        strap_s2_r <= strap_s1_r;
        ctl_s1_r <= {second_port_select, second_port_bus_enable};
        ctl_s2_r <= ctl_s1_r;
        pin_s1_r <= {pixel_valid_strobe, vertical_sync, horizontal_sync, remote_nack, pclk_present, link_detected};
        pin_s2_r <= pin_s1_r;
    end

    always @(posedge clk) begin
        if (regs_rst) begin
            strap_taken_r <= 1'b0;
            addr0_r <= 7'h00;
            addr1_r <= 7'h00;
            src_r <= 2'b00;
            sleep_r <= rst_rst_val[`SCR_BIT_SLEEP];
            crc_r <= gen_rst_val[`SCR_BIT_CRC_EN];
            filt_r <= gen_rst_val[`SCR_BIT_FILTER];
            pclk_auto_r <= gen_rst_val[`SCR_BIT_PCLK_AUTO];
            ack_r <= {2{gen_rst_val[`SCR_BIT_AUTO_ACK]}};
            pass_r <= {2{gen_rst_val[`SCR_BIT_PASS]}};
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            addr0_r <= strap;
            addr1_r <= p1en ? strap + 7'h01 : strap;
        end else begin
            if (wr_addr) begin
                if (sel1) begin
                    addr1_r <= reg_wdata[7:1];
                    src_r[1] <= reg_wdata[`SCR_BIT_ADDR_SRC];
                end else begin
                    addr0_r <= reg_wdata[7:1];
                    src_r[0] <= reg_wdata[`SCR_BIT_ADDR_SRC];
                end
            end
            if (wr_rst)
                sleep_r <= reg_wdata[`SCR_BIT_SLEEP];
            if (wr_gen) begin
                crc_r <= reg_wdata[`SCR_BIT_CRC_EN];
                filt_r <= reg_wdata[`SCR_BIT_FILTER];
                pclk_auto_r <= reg_wdata[`SCR_BIT_PCLK_AUTO];
                ack_r[sel1] <= reg_wdata[`SCR_BIT_AUTO_ACK];
                pass_r[sel1] <= reg_wdata[`SCR_BIT_PASS];
            end
        end
    end

    always @(posedge clk) begin
        if (reset || full_rst_r) begin
            full_rst_r <= 1'b0;
        end else begin
            full_rst_r <= wr_rst && reg_wdata[`SCR_BIT_FULL_RST];
        end
        if (reset) begin
            rst_cnt_r <= 4'h0;
        end else if ((wr_rst && reg_wdata[`SCR_BIT_LOGIC_RST]) || full_rst_r) begin
            rst_cnt_r <= `SCR_SOFT_RST_CYCLES;
        end else if (rst_cnt_r != 4'h0) begin
            rst_cnt_r <= rst_cnt_r - 4'h1;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `SCR_OFS_ADDR: reg_rdata <= sel1 ? {addr1_r, src_r[1]} : {addr0_r, src_r[0]};
                `SCR_OFS_RST: reg_rdata <= {sleep_r, 7'h00};
                `SCR_OFS_GEN: reg_rdata <= gen_rd_val;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    generate
        genvar g;
        // Each filter takes a change only once the input has differed for two cycles.
        for (g = 0; g < 3; g = g + 1) begin : g_filt
            reg [2:0] cnt_r;
            reg out_r;
            always @(posedge clk) begin
                if (reset || rst_cnt_r != 4'h0) begin
                    cnt_r <= 3'h0;
                    out_r <= 1'b0;
                end else if (!filt_r || vid_in[g] == out_r) begin
                    cnt_r <= 3'h0;
                    if (!filt_r)
                        out_r <= vid_in[g];
                end else if (cnt_r == `SCR_FILT_LAST) begin
                    cnt_r <= 3'h0;
                    out_r <= vid_in[g];
                end else begin
                    cnt_r <= cnt_r + 3'h1;
                end
            end
            assign filt_out[g] = out_r;
        end
    endgenerate

    always @(posedge clk) begin
        if (reset) begin
            port0_address <= 7'h00;
            port1_address <= 7'h00;
            power_down <= 1'b0;
            logic_reset <= 1'b1;
            crc_check_en <= 1'b0;
            auto_ack_en <= 2'b00;
            pass_through_en <= 2'b00;
            use_internal_osc <= 1'b0;
            nack_to_master <= 1'b0;
            horizontal_sync_out <= 1'b0;
            vertical_sync_out <= 1'b0;
            pixel_valid_out <= 1'b0;
        end else begin
            port0_address <= src_r[0] ? addr0_r : strap;
            port1_address <= src_r[1] ? addr1_r : strap + 7'h01;
            power_down <= sleep_r && !pin_s2_r[0];
            logic_reset <= rst_cnt_r != 4'h0 || full_rst_r;
            crc_check_en <= crc_r;
            auto_ack_en <= ack_r;
            pass_through_en <= pass_r;
            use_internal_osc <= pclk_auto_r && !pin_s2_r[1];
            nack_to_master <= pin_s2_r[2] && !scr_port_bit(ack_r, sel1);
            horizontal_sync_out <= filt_out[0];
            vertical_sync_out <= filt_out[1];
            pixel_valid_out <= filt_out[2];
        end
    end
endmodule // scr_control_regs
`default_nettype wire

// File: scr_control_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module scr_control_regs_sva (
    // Clock and bus.
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Status and controls.
    input wire logic link_detected,
    input wire logic pclk_present,
    input wire logic power_down,
    input wire logic logic_reset,
    input wire logic [1:0] auto_ack_en,
    input wire logic nack_to_master,
    input wire logic use_internal_osc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_unm; reg_rd && reg_addr == 8'h02 |=> reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_rst; reg_rd && reg_addr == 8'h01 |=> reg_rdata[6:0] == 7'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset register read");
    property p_gen; reg_rd && reg_addr == 8'h03 |=> (reg_rdata & 8'h45) == 8'h40; endproperty
    a_gen: assert property (p_gen) else $error("reserved bit read");
    property p_sr; reg_wr && reg_addr == 8'h01 && reg_wdata[1:0] != 2'b00 |-> ##[1:3] logic_reset; endproperty
    a_sr: assert property (p_sr) else $error("no soft reset");
    property p_len; $rose(logic_reset) |-> logic_reset [*4]; endproperty
    a_len: assert property (p_len) else $error("short soft reset");
    property p_slp; disable iff (reset || logic_reset) link_detected [*5] |-> !power_down; endproperty
    a_slp: assert property (p_slp) else $error("sleep with link");
    property p_nak; (auto_ack_en == 2'b11) [*4] |-> !nack_to_master; endproperty
    a_nak: assert property (p_nak) else $error("nack passed");
    property p_osc; disable iff (reset || logic_reset) pclk_present [*5] |-> !use_internal_osc; endproperty
    a_osc: assert property (p_osc) else $error("oscillator with clock");
    c_sr: cover property (reg_wr && reg_addr == 8'h01 && reg_wdata[0]);
    c_slp: cover property ($rose(power_down));
    c_osc: cover property ($rose(use_internal_osc));
endmodule // scr_control_regs_sva
bind scr_control_regs scr_control_regs_sva u_sva (
    .clk(clk),
    .reset(reset),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .link_detected(link_detected),
    .pclk_present(pclk_present),
    .power_down(power_down),
    .logic_reset(logic_reset),
    .auto_ack_en(auto_ack_en),
    .nack_to_master(nack_to_master),
    .use_internal_osc(use_internal_osc)
);
`default_nettype wire

// File: scr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scr_host_model (
    // Clock.
    input wire logic clk,
    // Register access.
    output var logic reg_wr,
    output var logic reg_rd,
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0_0000;
    // One master issues one access at a time.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(negedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
        @(negedge clk);
        q = reg_rdata;
    endtask
endmodule // scr_host_model
`default_nettype wire

// File: scr_regs.vh
`ifndef SCR_REGS_VH
`define SCR_REGS_VH
`define SCR_OFS_ADDR 8'h00
`define SCR_OFS_RST 8'h01
`define SCR_OFS_GEN 8'h03
`define SCR_GEN_RESET 8'hD2
`define SCR_RST_RESET 8'h00
`define SCR_BIT_ADDR_SRC 0
`define SCR_BIT_SLEEP 7
`define SCR_BIT_FULL_RST 1
`define SCR_BIT_LOGIC_RST 0
`define SCR_BIT_CRC_EN 7
`define SCR_BIT_AUTO_ACK 5
`define SCR_BIT_FILTER 4
`define SCR_BIT_PASS 3
`define SCR_BIT_PCLK_AUTO 1
`define SCR_GEN_COMMON_MASK 8'h92
`define SCR_RST_MASK 8'h80
`define SCR_SOFT_RST_CYCLES 4'h4
`define SCR_BIT_GEN_FIXED 6
`define SCR_FILT_LAST 3'h1
`endif

// File: tb_scr_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_scr_control_regs;
    logic clk = 1'b0, reset = 1'b1, second_port_bus_enable = 1'b1, second_port_select = 1'b0;
    logic link_detected = 1'b1, pclk_present = 1'b1, remote_nack = 1'b1, horizontal_sync = 1'b0;
    logic vertical_sync = 1'b0, pixel_valid_strobe = 1'b0, reg_wr, reg_rd, power_down, logic_reset;
    logic crc_check_en, use_internal_osc, nack_to_master, horizontal_sync_out, vertical_sync_out, pixel_valid_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q, seen;
    logic [6:0] address_strap_pin = 7'h0C, port0_address, port1_address;
    logic [1:0] auto_ack_en, pass_through_en;
    int compares = 0, miscompares = 0;
    scr_control_regs u_dut (.*);
    scr_host_model u_host (.*);
    initial forever #12.5 clk = ~clk;
    initial begin
        #100000 miscompares++;
        end_of_test;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        u_host.acc(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.acc(1'b1, a, d, q);
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        w(5);
        reset = 1'b0;
        w(6);
        rc(8'h00, 8'h18);
        rc(8'h01, 8'h00);
        rc(8'h02, 8'h00);
        rc(8'h03, 8'hD2);
        chk({1'b0, port1_address}, 8'h0D);
        chk({4'h0, auto_ack_en, pass_through_en}, 8'h00);
        chk({crc_check_en, nack_to_master, use_internal_osc, 5'h00}, 8'hC0);
        {horizontal_sync, vertical_sync, pixel_valid_strobe} = 3'b111;
        w(1);
        {horizontal_sync, vertical_sync, pixel_valid_strobe} = 3'b000;
        repeat (6) begin
            w(1);
            chk({5'h00, horizontal_sync_out, vertical_sync_out, pixel_valid_out}, 8'h00);
        end
        {horizontal_sync, vertical_sync, pixel_valid_strobe} = 3'b111;
        w(8);
        chk({5'h00, horizontal_sync_out, vertical_sync_out, pixel_valid_out}, 8'h07);
        pclk_present = 1'b0;
        w(6);
        chk({7'h00, use_internal_osc}, 8'h01);
        wr(8'h00, 8'h55);
        w(2);
        chk({1'b0, port0_address}, 8'h2A);
        rc(8'h00, 8'h55);
        second_port_select = 1'b1;
        w(4);
        rc(8'h00, 8'h1A);
        wr(8'h03, 8'hFF);
        rc(8'h03, 8'hFA);
        w(2);
        chk({4'h0, auto_ack_en, pass_through_en}, 8'h0A);
        second_port_select = 1'b0;
        w(4);
        wr(8'h03, 8'h20);
        w(6);
        chk({crc_check_en, nack_to_master, use_internal_osc, 1'b0, auto_ack_en, pass_through_en}, 8'h0E);
        {horizontal_sync, vertical_sync, pixel_valid_strobe} = 3'b000;
        w(4);
        {horizontal_sync, vertical_sync, pixel_valid_strobe} = 3'b111;
        w(1);
        {horizontal_sync, vertical_sync, pixel_valid_strobe} = 3'b000;
        seen = 8'h00;
        repeat (5) begin
            w(1);
            seen = seen | {5'h00, horizontal_sync_out, vertical_sync_out, pixel_valid_out};
        end
        chk(seen, 8'h07);
        chk({5'h00, horizontal_sync_out, vertical_sync_out, pixel_valid_out}, 8'h00);
        wr(8'h01, 8'h80);
        link_detected = 1'b0;
        w(6);
        chk({7'h00, power_down}, 8'h01);
        wr(8'h01, 8'h81);
        w(1);
        chk({7'h00, logic_reset}, 8'h01);
        w(6);
        rc(8'h01, 8'h80);
        link_detected = 1'b1;
        w(6);
        chk({7'h00, power_down}, 8'h00);
        second_port_bus_enable = 1'b0;
        wr(8'h01, 8'h82);
        w(1);
        chk({7'h00, logic_reset}, 8'h01);
        w(10);
        rc(8'h03, 8'hD2);
        rc(8'h01, 8'h00);
        rc(8'h00, 8'h18);
        second_port_select = 1'b1;
        w(4);
        rc(8'h00, 8'h18);
        end_of_test;
    end
endmodule // tb_scr_control_regs
`default_nettype wire
